// ===== core/gcs_consts.vh
`ifndef GCS_CONSTS_VH
`define GCS_CONSTS_VH
// Command codes (byte addresses of the standard command space)
`define GCS_CMD_CTRL_LO 8'h00
`define GCS_CMD_CTRL_HI 8'h01
`define GCS_CMD_TEMP 8'h02
`define GCS_CMD_VOLT 8'h04
`define GCS_CMD_FLAGS 8'h06
`define GCS_CMD_NOM_CAP 8'h08
`define GCS_CMD_FULL_CAP 8'h0A
`define GCS_CMD_REM_CAP 8'h0C
// Control subcommands
`define GCS_SUB_BAT_IN 16'h000C
`define GCS_SUB_BAT_OUT 16'h000D
`define GCS_SUB_CFG_UPD 16'h0013
`define GCS_SUB_SEAL 16'h0020
`define GCS_SUB_PULSE 16'h0023
`define GCS_SUB_CHEMISTRY_SELECT_CMD 16'h0030
`define GCS_SUB_CHEM_B 16'h0031
`define GCS_SUB_CHEM_C 16'h0032
`define GCS_SUB_RESET 16'h0041
`define GCS_SUB_SOFT_RESET 16'h0042
// Update-status seal bit
`define GCS_UPD_SEAL_BIT 7
// Flag word bit positions
`define GCS_FL_OT 15
`define GCS_FL_UT 14
`define GCS_FL_FC 9
`define GCS_FL_CHG 8
`define GCS_FL_OCV 7
`define GCS_FL_DODC 6
`define GCS_FL_POWER_ON_RESET_FLAG 5
`define GCS_FL_CFGUP 4
`define GCS_FL_BATDET 3
`define GCS_FL_LOW_CHARGE_WARN_FLAG 2
`define GCS_FL_FINAL_CHARGE_FLAG 1
`define GCS_FL_DSG 0
// Temperature source encodings
`define GCS_TSRC_INT 2'b00
`define GCS_TSRC_EXT 2'b01
`define GCS_TSRC_HOST 2'b10
// Thresholds, 0.1 K units and percent
`define GCS_OT_DEF 16'h0CD1
`define GCS_UT_DEF 16'h0AAB
`define GCS_THYS_DEF 16'h0032
`define GCS_FC_SET_DEF 8'hFF
`define GCS_FC_CLR_DEF 8'h62
`define GCS_CHG_CLR_FROM 8'h62
`define GCS_CHG_CLR_TO 8'h63
`define GCS_CHG_SET 8'h5F
`define GCS_VOLT_MAX 16'h1770
// Pulse timing
`define GCS_CLK_MHZ 100
`define GCS_PULSE_US 1000
`define GCS_PULSE_CYC (`GCS_PULSE_US * `GCS_CLK_MHZ)
`define GCS_UPD_RESET 8'h00
// Flag word after reset: only the power-on-reset flag is set
`define GCS_FLAGS_RESET 16'h0020
`endif

// ===== core/gcs_unit.v
`timescale 1ns/10ps
`include "gcs_consts.vh"
module gcs_unit #(
    parameter [31:0] PULSE_CYC = `GCS_PULSE_CYC
) (
    input wire clk,
    input wire rstn,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] cmd_addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    input wire [1:0] temperature_source_sel,
    input wire smoothing_enable,
    input wire insert_detect_enable,
    input wire battery_insert_pin,
    input wire [15:0] temp_internal,
    input wire [15:0] temp_thermistor,
    input wire [15:0] volt_meas,
    input wire [7:0] soc,
    input wire charging,
    input wire discharging_flag,
    input wire charge_term,
    input wire relax_entry,
    input wire ocv_sample,
    input wire depth_correction_flag,
    input wire [7:0] fc_set_pct,
    input wire [7:0] fc_clr_pct,
    input wire [7:0] low_charge_warn_flag_set,
    input wire [7:0] low_charge_warn_flag_clr,
    input wire [7:0] final_charge_flag_set,
    input wire [7:0] final_charge_flag_clr,
    input wire [15:0] rem_cap_filt,
    input wire [15:0] rem_cap_unfilt,
    input wire [15:0] nom_cap_uncomp,
    input wire [15:0] full_cap_uncomp,
    output reg gp_output_pin,
    output reg sealed,
    output reg [1:0] chem_sel,
    output reg chemistry_changed_flag,
    output reg [7:0] update_status,
    output reg defaults_reload,
    output reg soft_reset_pulse,
    output reg [15:0] flags_word
);
    // Pulse generator states; a pulse command seen in ST_PULSE is dropped
    // so a repeated command cannot stretch or restart the pulse
    localparam ST_IDLE = 2'b01;
    localparam ST_PULSE = 2'b10;

    // Low byte of the control word, held until the high byte arrives
    reg [7:0] ctrl_lo_q;
    // Host temperature commits as a whole word, so a reader never sees
    // a new low byte paired with an old high byte
    reg [15:0] temp_host_q;
    reg [7:0] temp_lo_q;
    reg [1:0] pst_q;
    reg [31:0] pcnt_q;
    reg [2:0] bin_sync_q;
    reg bin_level_q;
    reg [7:0] soc_prev_q;
    reg [15:0] temp_word;
    reg [15:0] volt_word;
    reg [15:0] rd_word;
    wire [15:0] sub_cmd;
    wire sub_stb;
    wire bin_fall;

    // Low byte at even code, high byte at odd code
    // word pairing
    assign sub_cmd = {wr_data, ctrl_lo_q};
    assign sub_stb = wr_stb && (cmd_addr == `GCS_CMD_CTRL_HI);

    always @* begin
        case (temperature_source_sel)
            `GCS_TSRC_INT: temp_word = temp_internal;
            `GCS_TSRC_EXT: temp_word = temp_thermistor;
            `GCS_TSRC_HOST: temp_word = temp_host_q;
            default: temp_word = temp_internal;
        endcase
    end

    always @* begin
        if (volt_meas > `GCS_VOLT_MAX) begin
            volt_word = `GCS_VOLT_MAX;
        end else begin
            volt_word = volt_meas;
        end
    end

    // Read word is selected by the even code; the odd code picks its high byte.
    // Unknown codes read as zero rather than aliasing a live register.
    always @* begin
        case ({cmd_addr[7:1], 1'b0})
            `GCS_CMD_TEMP: rd_word = temp_word;
            `GCS_CMD_VOLT: rd_word = volt_word;
            `GCS_CMD_FLAGS: rd_word = flags_word;
            `GCS_CMD_NOM_CAP: rd_word = nom_cap_uncomp;
            `GCS_CMD_FULL_CAP: rd_word = full_cap_uncomp;
            `GCS_CMD_REM_CAP: rd_word = smoothing_enable ? rem_cap_filt : rem_cap_unfilt;
            default: rd_word = 16'h0000;
        endcase
    end

    // Read byte is registered and held until the next read strobe
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else if (rd_stb) begin
            rd_data <= cmd_addr[0] ? rd_word[15:8] : rd_word[7:0];
        end
    end

    // Pin synchroniser: change accepted once stages 2 and 3 agree
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bin_sync_q <= 3'b111;
            bin_level_q <= 1'b1;
        end else begin
            bin_sync_q <= {bin_sync_q[1:0], battery_insert_pin};
            if (bin_sync_q[1] == bin_sync_q[2]) begin
                bin_level_q <= bin_sync_q[2];
            end
        end
    end
    // Pin idles high; level and stages reset high so release gives no false fall.
    // A glitch shorter than one clock never reaches the accepted level.
    assign bin_fall = bin_level_q && (bin_sync_q[1] == bin_sync_q[2]) && !bin_sync_q[2];

    // Command decode and control state.
    // Subcommands act on the write to the odd control code, using the last
    // low byte written; writing only the low byte has no effect of its own.
    // Refused commands are dropped silently: the host sees no error status.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_lo_q <= 8'h00;
            temp_host_q <= 16'h0000;
            temp_lo_q <= 8'h00;
            sealed <= 1'b0;
            chem_sel <= 2'b00;
            chemistry_changed_flag <= 1'b0;
            update_status <= `GCS_UPD_RESET;
            defaults_reload <= 1'b0;
            soft_reset_pulse <= 1'b0;
            flags_word <= `GCS_FLAGS_RESET;
            soc_prev_q <= 8'h00;
        end else begin
            defaults_reload <= 1'b0;
            soft_reset_pulse <= 1'b0;
            soc_prev_q <= soc;
            if (wr_stb && cmd_addr == `GCS_CMD_CTRL_LO) begin
                ctrl_lo_q <= wr_data;
            end
            // host temperature written only in host mode, sealed blocks it
            if (wr_stb && !sealed && temperature_source_sel == `GCS_TSRC_HOST) begin
                if (cmd_addr == `GCS_CMD_TEMP) begin
                    temp_lo_q <= wr_data;
                end
                if (cmd_addr == (`GCS_CMD_TEMP + 8'h01)) begin
                    temp_host_q <= {wr_data, temp_lo_q};
                end
            end
            if (sub_stb) begin
                case (sub_cmd)
                    `GCS_SUB_SEAL: begin
                        sealed <= 1'b1;
                        update_status[`GCS_UPD_SEAL_BIT] <= 1'b1;
                    end
                    `GCS_SUB_CHEMISTRY_SELECT_CMD, `GCS_SUB_CHEM_B, `GCS_SUB_CHEM_C: begin
                        if (!sealed) begin
                            chem_sel <= sub_cmd[1:0];
                            chemistry_changed_flag <= 1'b1;
                        end
                    end
                    `GCS_SUB_RESET: begin
                        if (!sealed) begin
                            defaults_reload <= 1'b1;
                            update_status <= `GCS_UPD_RESET;
                            chemistry_changed_flag <= 1'b0;
                        end
                    end
                    `GCS_SUB_SOFT_RESET: begin
                        if (!sealed) begin
                            soft_reset_pulse <= 1'b1;
                            chemistry_changed_flag <= 1'b0;
                            if (flags_word[`GCS_FL_CFGUP] && update_status[`GCS_UPD_SEAL_BIT]) begin
                                sealed <= 1'b1;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
            flags_word[13:10] <= 4'h0;
            flags_word[`GCS_FL_DSG] <= discharging_flag;
            flags_word[`GCS_FL_DODC] <= depth_correction_flag;
            // Temperature flags hold between the set and clear points,
            // so a reading hovering at a threshold does not toggle them
            // over-temperature
            if (temp_word >= `GCS_OT_DEF) begin
                flags_word[`GCS_FL_OT] <= 1'b1;
            end else if (temp_word < `GCS_OT_DEF - `GCS_THYS_DEF) begin
                flags_word[`GCS_FL_OT] <= 1'b0;
            end
            if (temp_word <= `GCS_UT_DEF) begin
                flags_word[`GCS_FL_UT] <= 1'b1;
            end else if (temp_word > `GCS_UT_DEF + `GCS_THYS_DEF) begin
                flags_word[`GCS_FL_UT] <= 1'b0;
            end
            if (fc_set_pct[7] ? charge_term : (soc >= fc_set_pct)) begin
                flags_word[`GCS_FL_FC] <= 1'b1;
            end else if (soc <= fc_clr_pct) begin
                flags_word[`GCS_FL_FC] <= 1'b0;
            end
            // Clear needs the exact 98 to 99 step while charging; a jump past it
            // leaves the permission set until the next such step
            // fast-charge permission
            if (soc <= `GCS_CHG_SET) begin
                flags_word[`GCS_FL_CHG] <= 1'b1;
            end else if (charging && soc_prev_q == `GCS_CHG_CLR_FROM && soc == `GCS_CHG_CLR_TO) begin
                flags_word[`GCS_FL_CHG] <= 1'b0;
            end
            if (ocv_sample) begin
                flags_word[`GCS_FL_OCV] <= 1'b1;
            end else if (relax_entry) begin
                flags_word[`GCS_FL_OCV] <= 1'b0;
            end
            if (soc <= low_charge_warn_flag_set) begin
                flags_word[`GCS_FL_LOW_CHARGE_WARN_FLAG] <= 1'b1;
            end else if (soc >= low_charge_warn_flag_clr) begin
                flags_word[`GCS_FL_LOW_CHARGE_WARN_FLAG] <= 1'b0;
            end
            if (soc <= final_charge_flag_set) begin
                flags_word[`GCS_FL_FINAL_CHARGE_FLAG] <= 1'b1;
            end else if (soc >= final_charge_flag_clr) begin
                flags_word[`GCS_FL_FINAL_CHARGE_FLAG] <= 1'b0;
            end
            if (insert_detect_enable) begin
                if (bin_fall) begin
                    flags_word[`GCS_FL_BATDET] <= 1'b1;
                end
            end else if (sub_stb && sub_cmd == `GCS_SUB_BAT_IN) begin
                flags_word[`GCS_FL_BATDET] <= 1'b1;
            end else if (sub_stb && sub_cmd == `GCS_SUB_BAT_OUT) begin
                flags_word[`GCS_FL_BATDET] <= 1'b0;
            end
            if (sub_stb && !sealed) begin
                if (sub_cmd == `GCS_SUB_CFG_UPD) begin
                    flags_word[`GCS_FL_CFGUP] <= 1'b1;
                end else if (sub_cmd == `GCS_SUB_RESET) begin
                    flags_word[`GCS_FL_POWER_ON_RESET_FLAG] <= 1'b1;
                    flags_word[`GCS_FL_CFGUP] <= 1'b0;
                end else if (sub_cmd == `GCS_SUB_SOFT_RESET) begin
                    flags_word[`GCS_FL_POWER_ON_RESET_FLAG] <= 1'b0;
                    flags_word[`GCS_FL_CFGUP] <= 1'b0;
                end
            end
        end
    end

    // Pulse starts the cycle after the command, well inside the allowed delay.
    // Length is PULSE_CYC clocks; the default gives one millisecond at 100 MHz.
    // output pulse
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pst_q <= ST_IDLE;
            pcnt_q <= 32'h0;
            gp_output_pin <= 1'b0;
        end else begin
            case (pst_q)
                ST_IDLE: begin
                    gp_output_pin <= 1'b0;
                    if (sub_stb && sub_cmd == `GCS_SUB_PULSE) begin
                        pst_q <= ST_PULSE;
                        pcnt_q <= PULSE_CYC - 32'h1;
                        gp_output_pin <= 1'b1;
                    end
                end
                ST_PULSE: begin
                    if (pcnt_q == 32'h0) begin
                        pst_q <= ST_IDLE;
                        gp_output_pin <= 1'b0;
                    end else begin
                        pcnt_q <= pcnt_q - 32'h1;
                    end
                end
                default: pst_q <= ST_IDLE;
            endcase
        end
    end
endmodule // gcs_unit

// ===== dv/gcs_host_model.sv
`timescale 1ns/10ps
module gcs_host_model (
    input wire logic clk,
    output logic wr_stb,
    output logic rd_stb,
    output logic [7:0] cmd_addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    initial begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        cmd_addr = 8'hFF;
        wr_data = 8'h5A;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        wr_stb = w;
        rd_stb = !w;
        cmd_addr = a;
        wr_data = d;
        @(negedge clk);
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        // Released lines must not keep the last value
        cmd_addr = ~a;
        wr_data = ~d;
        q = rd_data;
    endtask
    task automatic wrw(input logic [7:0] a, input logic [15:0] v);
        logic [7:0] q;
        xfer(1'b1, a, v[7:0], q);
        xfer(1'b1, a + 8'h01, v[15:8], q);
    endtask
    task automatic rdw(input logic [7:0] a, output logic [15:0] v);
        xfer(1'b0, a, 8'h00, v[7:0]);
        xfer(1'b0, a + 8'h01, 8'h00, v[15:8]);
    endtask
endmodule // gcs_host_model

// ===== dv/gcs_unit_props.sv
`timescale 1ns/10ps
`include "gcs_consts.vh"
module gcs_unit_props #(
    parameter [31:0] PULSE_CYC = 32'h14
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic insert_detect_enable,
    input wire logic gp_output_pin,
    input wire logic sealed,
    input wire logic [1:0] chem_sel,
    input wire logic chemistry_changed_flag,
    input wire logic [7:0] update_status,
    input wire logic defaults_reload,
    input wire logic soft_reset_pulse,
    input wire logic [15:0] flags_word
);
    reg [7:0] lo_q;
    reg [31:0] hi_q;
    wire go = wr_stb && cmd_addr == 8'h01;
    wire [15:0] sub_code = {wr_data, lo_q};
    // Low byte of the pending subcommand and length of the current pulse
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lo_q <= 8'h00;
            hi_q <= 32'h0;
        end else begin
            if (wr_stb && cmd_addr == 8'h00) begin
                lo_q <= wr_data;
            end
            hi_q <= gp_output_pin ? hi_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_seal; go && sub_code == `GCS_SUB_SEAL |=> sealed && update_status[7]; endproperty
    a_seal: assert property (p_seal) else $error("seal not taken");
    property p_lock; go && sealed && sub_code[15:4] == 12'h003 |=> $stable(chem_sel); endproperty
    a_lock: assert property (p_lock) else $error("chemistry changed while sealed");
    property p_pulse; go && sub_code == `GCS_SUB_PULSE && !gp_output_pin |=> gp_output_pin; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse not started");
    property p_plen; $fell(gp_output_pin) |-> hi_q == PULSE_CYC; endproperty
    a_plen: assert property (p_plen) else $error("pulse length wrong");
    property p_chem; go && !sealed && sub_code == `GCS_SUB_CHEM_B |=> chem_sel == 2'h1 && chemistry_changed_flag;
    endproperty
    a_chem: assert property (p_chem) else $error("chemistry select wrong");
    property p_rst; go && !sealed && sub_code == `GCS_SUB_RESET |=> defaults_reload && flags_word[5]; endproperty
    a_rst: assert property (p_rst) else $error("full reset wrong");
    property p_soft; go && !sealed && sub_code == `GCS_SUB_SOFT_RESET |=> soft_reset_pulse && flags_word[5:4] == 2'h0;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset wrong");
    property p_reseal; go && !sealed && sub_code == `GCS_SUB_SOFT_RESET && flags_word[4] && update_status[7] |=> sealed;
    endproperty
    a_reseal: assert property (p_reseal) else $error("no reseal");
    property p_volt; rd_stb && cmd_addr == 8'h05 |=> rd_data <= 8'h17; endproperty
    a_volt: assert property (p_volt) else $error("voltage above limit");
    property p_rsvd; flags_word[13:10] == 4'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved flag set");
    property p_bat; go && !insert_detect_enable && sub_code == `GCS_SUB_BAT_IN |=> flags_word[3]; endproperty
    a_bat: assert property (p_bat) else $error("battery present not set");
    cover property (go && sub_code == `GCS_SUB_PULSE);
    cover property (go && sealed);
    cover property ($fell(gp_output_pin));
endmodule // gcs_unit_props
bind gcs_unit gcs_unit_props #(.PULSE_CYC(PULSE_CYC)) gcs_unit_props_i (.*);

// ===== dv/tb_gcs_unit.sv
`timescale 1ns/10ps
`include "gcs_consts.vh"
module tb_gcs_unit;
    localparam int PC = 20;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr_stb, rd_stb, gp_output_pin, sealed, chemistry_changed_flag, defaults_reload, soft_reset_pulse;
    logic [7:0] cmd_addr, wr_data, rd_data, update_status;
    logic [1:0] temperature_source_sel = 2'h0;
    logic [1:0] chem_sel;
    logic smoothing_enable = 1'b0, insert_detect_enable = 1'b0, battery_insert_pin = 1'b1, charging = 1'b1;
    logic discharging_flag = 1'b0, charge_term = 1'b0, relax_entry = 1'b0, ocv_sample = 1'b0;
    logic depth_correction_flag = 1'b0;
    logic [15:0] temp_internal = 16'h0BB8, temp_thermistor = 16'h0BB8, volt_meas = 16'h0;
    logic [15:0] rem_cap_filt = 16'h0, rem_cap_unfilt = 16'h0, nom_cap_uncomp = 16'h0, full_cap_uncomp = 16'h0;
    logic [7:0] soc = 8'h32, fc_set_pct = 8'h64, fc_clr_pct = 8'h62;
    logic [7:0] low_charge_warn_flag_set = 8'h0A, low_charge_warn_flag_clr = 8'h0F, final_charge_flag_set = 8'h05, final_charge_flag_clr = 8'h08;
    logic [15:0] flags_word, v, ht;
    logic [31:0] r;
    int errors = 0, samples_checked = 0, seed = 93715, cyc = 0, hc = 0, n;
    logic [15:0] tv [8] = '{16'h0CD0, 16'h0CD1, 16'h0C9F, 16'h0C9E, 16'h0AAC, 16'h0AAB, 16'h0ADD, 16'h0ADE};
    logic [1:0] te [8] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0};
    logic [7:0] sv [11] = '{8'h5F, 8'h62, 8'h63, 8'h64, 8'h63, 8'h62, 8'h5F, 8'h0A, 8'h05, 8'h08, 8'h0F};
    logic [3:0] se [11] = '{4'h4, 4'h4, 4'h0, 4'h8, 4'h8, 4'h0, 4'h4, 4'h6, 4'h7, 4'h6, 4'h4};
    gcs_unit #(.PULSE_CYC(PC)) gcs_unit_i (.*);
    gcs_host_model gcs_host_model_i (.*);
    always #5 clk = ~clk;
    always @(negedge clk) if (gp_output_pin === 1'b1) hc++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            stop_test();
        end
    end
    function automatic logic [15:0] exp_volt(input logic [15:0] m);
        return m > 16'h1770 ? 16'h1770 : m;
    endfunction
    function automatic logic [15:0] exp_temp(input logic [1:0] s, input logic [15:0] i, e, h);
        return s == 2'h0 ? i : (s == 2'h1 ? e : h);
    endfunction
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", w, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wt(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic fl(input int b, input logic e);
        wt(6);
        chk($sformatf("flag%0d", b), 16'(e), 16'(flags_word[b]));
    endtask
    task automatic sub(input logic [15:0] c);
        gcs_host_model_i.wrw(8'h00, c);
        wt(1);
    endtask
    initial begin
        wt(6);
        rstn = 1'b1;
        chk("reset", 16'h0020, {5'h0, sealed, chem_sel, update_status} | {10'h0, flags_word[5], 5'h0});
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            volt_meas = i < 2 ? 16'h1770 + 16'(i) : r[15:0];
            {rem_cap_filt, rem_cap_unfilt} = $random(seed);
            {nom_cap_uncomp, full_cap_uncomp} = $random(seed);
            {temp_internal, temp_thermistor} = $random(seed);
            {smoothing_enable, discharging_flag, depth_correction_flag} = r[18:16];
            temperature_source_sel = 2'(i % 3);
            gcs_host_model_i.wrw(`GCS_CMD_TEMP, r[31:16]);
            if (temperature_source_sel == 2'h2) ht = r[31:16];
            gcs_host_model_i.rdw(`GCS_CMD_TEMP, v);
            chk("temp", exp_temp(temperature_source_sel, temp_internal, temp_thermistor, ht), v);
            gcs_host_model_i.rdw(`GCS_CMD_VOLT, v);
            chk("volt", exp_volt(volt_meas), v);
            gcs_host_model_i.rdw(`GCS_CMD_REM_CAP, v);
            chk("remcap", smoothing_enable ? rem_cap_filt : rem_cap_unfilt, v);
            gcs_host_model_i.rdw(`GCS_CMD_NOM_CAP, v);
            chk("nomcap", nom_cap_uncomp, v);
            gcs_host_model_i.rdw(`GCS_CMD_FULL_CAP, v);
            chk("fullcap", full_cap_uncomp, v);
            gcs_host_model_i.rdw(`GCS_CMD_FLAGS, v);
            chk("flaglow", {13'h0, depth_correction_flag, discharging_flag, 1'b0}, {13'h0, v[6], v[0], v[13:10] != 4'h0});
        end
        temperature_source_sel = 2'h0;
        temp_internal = 16'h0BB8;
        wt(3);
        for (int i = 0; i < 8; i++) begin
            temp_internal = tv[i];
            wt(3);
            gcs_host_model_i.rdw(`GCS_CMD_FLAGS, v);
            chk("otut", 16'(te[i]), 16'(v[15:14]));
        end
        for (int i = 0; i < 11; i++) begin
            soc = sv[i];
            wt(4);
            chk("socflags", 16'(se[i]), {12'h0, flags_word[9:8], flags_word[2:1]});
        end
        fc_set_pct = 8'hFF;
        charge_term = 1'b1;
        fl(9, 1'b1);
        relax_entry = 1'b1;
        wt(1);
        relax_entry = 1'b0;
        fl(7, 1'b0);
        ocv_sample = 1'b1;
        wt(1);
        ocv_sample = 1'b0;
        fl(7, 1'b1);
        for (int k = 0; k < 3; k++) begin
            sub(`GCS_SUB_CHEMISTRY_SELECT_CMD + 16'(k));
            chk("chem", 16'(k) | 16'h0100, {7'h0, chemistry_changed_flag, 6'h0, chem_sel});
            sub(`GCS_SUB_SOFT_RESET);
            chk("soft", 16'h0, {13'h0, flags_word[5:4], chemistry_changed_flag});
        end
        sub(`GCS_SUB_CFG_UPD);
        fl(4, 1'b1);
        sub(`GCS_SUB_SOFT_RESET);
        fl(4, 1'b0);
        sub(`GCS_SUB_RESET);
        fl(5, 1'b1);
        // pulse command sent twice; the second command falls inside the pulse and is dropped, so the pin pulses once
        sub(`GCS_SUB_PULSE);
        sub(`GCS_SUB_PULSE);
        wt(PC + 4);
        chk("pulse", 16'(PC), 16'(hc));
        sub(`GCS_SUB_BAT_IN);
        fl(3, 1'b1);
        sub(`GCS_SUB_BAT_OUT);
        fl(3, 1'b0);
        insert_detect_enable = 1'b1;
        sub(`GCS_SUB_BAT_IN);
        fl(3, 1'b0);
        repeat (4) begin
            wt(4);
            battery_insert_pin = ~battery_insert_pin;
        end
        fl(3, 1'b1);
        temperature_source_sel = 2'h2;
        ht = 16'h0B00;
        gcs_host_model_i.wrw(`GCS_CMD_TEMP, ht);
        n = chem_sel;
        sub(`GCS_SUB_SEAL);
        chk("seal", 16'h0180, {7'h0, sealed, update_status});
        sub(`GCS_SUB_CHEMISTRY_SELECT_CMD);
        chk("chemlock", 16'(n), 16'(chem_sel));
        sub(`GCS_SUB_SOFT_RESET);
        fl(5, 1'b1);
        gcs_host_model_i.wrw(`GCS_CMD_TEMP, ~ht);
        gcs_host_model_i.rdw(`GCS_CMD_TEMP, v);
        chk("templock", ht, v);
        stop_test();
    end
endmodule // tb_gcs_unit
